// >>> logic/tft_timing_pkg.sv
// shared constants, modes and carriers of the source timing front end
package tft_timing_pkg;
  // clock and internal pattern pixel rate
  localparam int SYS_PERIOD_NS = 20;
  localparam int PAT_PERIOD_NS = 40;
  localparam int PAT_DIV = (PAT_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [3:0] PAT_LAST = 4'(PAT_DIV - 1);
  localparam logic [1:0] SYNC_SETTLE = 2'h2;

  // resolution codes
  typedef enum logic [1:0] {
    RES_800X480 = 2'b00,
    RES_800X600 = 2'b01,
    RES_400X480 = 2'b10,
    RES_400X240 = 2'b11
  } res_t;

  // line and frame geometry, in pixel ticks and lines
  localparam logic [10:0] H_ACT_800 = 11'h320;
  localparam logic [10:0] H_ACT_400 = 11'h190;
  localparam logic [10:0] V_ACT_480 = 11'h1e0;
  localparam logic [10:0] V_ACT_600 = 11'h258;
  localparam logic [10:0] V_ACT_240 = 11'h0f0;
  localparam logic [10:0] H_BACK = 11'h02e;
  localparam logic [10:0] V_BACK = 11'h017;
  localparam logic [10:0] PAT_HFRONT = 11'h010;
  localparam logic [10:0] PAT_VFRONT = 11'h007;
  localparam logic [10:0] CNT_MAX = 11'h7ff;
  localparam logic [10:0] CKV_TICKS = 11'h008;
  localparam logic [10:0] OEV_TICKS = 11'h00c;

  // column mapping
  localparam logic [10:0] PIX_PER_CHIP = 11'h190;
  localparam logic [10:0] LAST_TRIPLET = 11'h4ad;
  localparam int GRAY_W = 6;
  localparam logic [5:0] GRAY_MAX = 6'h3f;

  // multi-function bus layout for gate signals
  localparam int MIO_W = 18;
  localparam int MIO_OE = 2;
  localparam int MIO_DIR = 4;
  localparam int MIO_CLK = 6;
  localparam int MIO_STA = 8;
  localparam int MIO_STB = 10;
  localparam int MIO_STA2 = 12;
  localparam int MIO_LOAD = 16;
  localparam logic [17:0] GATE_MASK = 18'h11554;
  localparam logic [17:0] ALL_MASK = 18'h3ffff;

  typedef struct packed {
    res_t res;
    logic dither_disable;
    logic frame_rate_dither;
    logic sample_edge_select;
    logic dual_gate_enable;
    logic standby_n;
    logic primary_role_select;
    logic primary_side_select;
    logic source_shift_direction;
    logic gate_scan_direction;
    logic self_pattern_enable;
    logic chain_enable;
    logic white_default_select;
    logic data_invert;
    logic de_mode;
  } cfg_t;

  localparam cfg_t CFG_DEFAULT = '{res: RES_800X480, dither_disable: 1'h1,
    frame_rate_dither: 1'h1, sample_edge_select: 1'h0, dual_gate_enable: 1'h0,
    standby_n: 1'h1, primary_role_select: 1'h1, primary_side_select: 1'h0,
    source_shift_direction: 1'h1, gate_scan_direction: 1'h0,
    self_pattern_enable: 1'h0, chain_enable: 1'h1, white_default_select: 1'h1,
    data_invert: 1'h0, de_mode: 1'h1};

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pix_in_t;

  typedef struct packed {
    logic pclk;
    logic hs_n;
    logic vs_n;
    logic de;
    pix_in_t pix;
    cfg_t cfg;
  } pin_bundle_t;

  localparam pin_bundle_t PINS_IDLE = '{pclk: 1'h0, hs_n: 1'h1, vs_n: 1'h1, de: 1'h0,
    pix: '0, cfg: CFG_DEFAULT};

  typedef struct packed {
    logic valid;
    logic [10:0] column;
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
    logic polarity;
  } pix_out_t;

  typedef struct packed {
    logic vstart_a;
    logic vstart_b;
    logic dir;
    logic oe;
    logic shift_clk;
    logic load_n;
  } gate_t;

  localparam gate_t GATE_IDLE = '{vstart_a: 1'h0, vstart_b: 1'h0, dir: 1'h0, oe: 1'h0,
    shift_clk: 1'h0, load_n: 1'h1};
endpackage

// >>> logic/pin_sync.sv
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins in, synchronised copy out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q_ff
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// >>> logic/tft_source_timing_pin_config.sv
// pin-configured timing front end of a 1200-channel source driver
`timescale 1ns/1ns
`default_nettype none
module tft_source_timing_pin_config (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // parallel video from host
  input wire logic [7:0] red_in,
  input wire logic [7:0] green_in,
  input wire logic [7:0] blue_in,
  input wire logic pixel_clock_in,
  input wire logic line_sync_n,
  input wire logic frame_sync_n,
  input wire logic input_data_valid,
  // configuration pins
  input wire logic [1:0] resolution_select,
  input wire logic dither_disable,
  input wire logic frame_rate_dither,
  input wire logic sample_edge_select,
  input wire logic dual_gate_enable,
  input wire logic standby_n,
  input wire logic primary_role_select,
  input wire logic primary_side_select,
  input wire logic source_shift_direction,
  input wire logic gate_scan_direction,
  input wire logic self_pattern_enable,
  input wire logic chain_enable,
  input wire logic white_default_select,
  input wire logic data_invert,
  input wire logic data_valid_mode,
  // pixel stream to the column stage
  output tft_timing_pkg::pix_out_t column_outputs,
  // multi-function buses and chain clock
  input wire logic [17:0] right_multi_io_in,
  output logic [17:0] right_multi_io_out,
  output logic [17:0] right_multi_io_oe,
  input wire logic [17:0] left_multi_io_in,
  output logic [17:0] left_multi_io_out,
  output logic [17:0] left_multi_io_oe,
  input wire logic chain_clock_in,
  output logic chain_clock_out,
  output logic chain_clock_oe
);
  logic rstMeta_ff;
  logic rstn_ff;
  tft_timing_pkg::pin_bundle_t pinsRaw;
  tft_timing_pkg::pin_bundle_t syncd;
  tft_timing_pkg::cfg_t cfg_ff;
  logic [1:0] settleCnt_ff;
  logic cfgValid_ff;
  logic pclkPrev_ff, hsPrev_ff, vsPrev_ff, dePrev_ff, activePrev_ff;
  logic [3:0] patCnt_ff;
  logic [10:0] hCnt_ff, vCnt_ff, pixCnt_ff, lineCnt_ff;
  logic [1:0] frameCnt_ff;
  logic vstartOn_ff, loadPulse_ff, chainClk_ff;
  logic [17:0] fwdData_ff;
  tft_timing_pkg::gate_t gate_ff;
  tft_timing_pkg::gate_t nxt_gate;
  tft_timing_pkg::pix_out_t nxt_pixOut;

  // partner-to-primary traffic is not consumed here; these inputs are only terminated
  wire unusedIn = ^{right_multi_io_in, left_multi_io_in, chain_clock_in};

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rstMeta_ff <= 1'h0;
      rstn_ff <= 1'h0;
    end else begin
      rstMeta_ff <= 1'h1;
      rstn_ff <= rstMeta_ff;
    end
  end

  // 18-bit hosts tie the low bits low; nothing to do on this side
  assign pinsRaw = '{pclk: pixel_clock_in, hs_n: line_sync_n, vs_n: frame_sync_n,
    de: input_data_valid, pix: '{red: red_in, green: green_in, blue: blue_in},
    cfg: '{res: tft_timing_pkg::res_t'(resolution_select), dither_disable: dither_disable,
      frame_rate_dither: frame_rate_dither, sample_edge_select: sample_edge_select,
      dual_gate_enable: dual_gate_enable, standby_n: standby_n,
      primary_role_select: primary_role_select, primary_side_select: primary_side_select,
      source_shift_direction: source_shift_direction,
      gate_scan_direction: gate_scan_direction, self_pattern_enable: self_pattern_enable,
      chain_enable: chain_enable, white_default_select: white_default_select,
      data_invert: data_invert, de_mode: data_valid_mode}};

  // pixel clock is oversampled; only useful well below half of clk_sys
  pin_sync #(
    .W($bits(tft_timing_pkg::pin_bundle_t)),
    .RST_VAL(tft_timing_pkg::PINS_IDLE)
  ) u_pins (
    .clk(clk_sys),
    .rstn(rstn_ff),
    .d(pinsRaw),
    .q_ff(syncd)
  );

  // standby and self pattern act at once: a stopped host clock gives no frame edge
  wire patternOn = syncd.cfg.self_pattern_enable;
  wire running = syncd.cfg.standby_n & cfgValid_ff;
  wire deMode = cfg_ff.de_mode & ~patternOn;
  wire cascadeOn = cfg_ff.chain_enable & ~cfg_ff.dual_gate_enable;
  wire isPrimary = cfg_ff.primary_role_select;

  wire [10:0] hWidth = cfg_ff.res[1] ? tft_timing_pkg::H_ACT_400 : tft_timing_pkg::H_ACT_800;
  wire [10:0] vHeight = (cfg_ff.res == tft_timing_pkg::RES_800X600) ? tft_timing_pkg::V_ACT_600 :
    (cfg_ff.res == tft_timing_pkg::RES_400X240) ? tft_timing_pkg::V_ACT_240 :
    tft_timing_pkg::V_ACT_480;
  wire [10:0] hActEnd = 11'(tft_timing_pkg::H_BACK + hWidth);
  wire [10:0] vActEnd = 11'(tft_timing_pkg::V_BACK + vHeight);
  wire [10:0] hLast = 11'(hActEnd + tft_timing_pkg::PAT_HFRONT - 11'h001);
  wire [10:0] vLast = 11'(vActEnd + tft_timing_pkg::PAT_VFRONT - 11'h001);

  // pixel tick on the selected edge or from the pattern divider
  wire extRise = syncd.pclk & ~pclkPrev_ff;
  wire extFall = ~syncd.pclk & pclkPrev_ff;
  wire extTick = cfg_ff.sample_edge_select ? extRise : extFall;
  wire patTick = patCnt_ff == tft_timing_pkg::PAT_LAST;
  wire pixTick = running & (patternOn ? patTick : extTick);

  // falling sync edges mark line and frame starts; in data-valid mode a rising data valid marks line starts
  wire hsFall = hsPrev_ff & ~syncd.hs_n;
  wire vsFall = vsPrev_ff & ~syncd.vs_n;
  wire deRise = syncd.de & ~dePrev_ff;
  // hCnt_ff and vCnt_ff park at their maximum after reset; >= lets the pattern start from there
  wire patLineEnd = hCnt_ff >= hLast;
  wire lineStart = pixTick & (patternOn ? patLineEnd : (deMode ? deRise : hsFall));
  wire frameStart = patternOn ? (lineStart & (vCnt_ff >= vLast)) : (pixTick & vsFall);
  wire syncActive = (hCnt_ff >= tft_timing_pkg::H_BACK) && (hCnt_ff < hActEnd) &&
    (vCnt_ff >= tft_timing_pkg::V_BACK) && (vCnt_ff < vActEnd);
  wire activeNow = deMode ? syncd.de : syncActive;
  wire lineEnd = pixTick & activePrev_ff & ~activeNow;

  // configuration capture
  wire cfgLoad = (~cfgValid_ff & (settleCnt_ff == tft_timing_pkg::SYNC_SETTLE)) | frameStart;

  always_ff @(posedge clk_sys or negedge rstn_ff) begin
    if (!rstn_ff) begin
      settleCnt_ff <= 2'h0;
      cfgValid_ff <= 1'h0;
      cfg_ff <= tft_timing_pkg::CFG_DEFAULT;
    end else begin
      if (settleCnt_ff != tft_timing_pkg::SYNC_SETTLE) begin
        settleCnt_ff <= 2'(settleCnt_ff + 2'h1);
      end
      if (cfgLoad) begin
        cfg_ff <= syncd.cfg;
        cfgValid_ff <= 1'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn_ff) begin
    if (!rstn_ff) begin
      pclkPrev_ff <= 1'h0;
      patCnt_ff <= 4'h0;
    end else begin
      pclkPrev_ff <= syncd.pclk;
      patCnt_ff <= patTick ? 4'h0 : 4'(patCnt_ff + 4'h1);
    end
  end

  // raster counters, stepped on pixel ticks only
  always_ff @(posedge clk_sys or negedge rstn_ff) begin
    if (!rstn_ff) begin
      hsPrev_ff <= 1'h1;
      vsPrev_ff <= 1'h1;
      dePrev_ff <= 1'h0;
      activePrev_ff <= 1'h0;
      hCnt_ff <= tft_timing_pkg::CNT_MAX;
      vCnt_ff <= tft_timing_pkg::CNT_MAX;
      pixCnt_ff <= 11'h000;
      lineCnt_ff <= 11'h000;
      frameCnt_ff <= 2'h0;
    end else if (pixTick) begin
      hsPrev_ff <= syncd.hs_n;
      vsPrev_ff <= syncd.vs_n;
      dePrev_ff <= syncd.de;
      activePrev_ff <= activeNow;
      if (lineStart) begin
        hCnt_ff <= 11'h000;
      end else if (hCnt_ff != tft_timing_pkg::CNT_MAX) begin
        hCnt_ff <= 11'(hCnt_ff + 11'h001);
      end
      if (frameStart) begin
        vCnt_ff <= 11'h000;
      end else if (lineStart && vCnt_ff != tft_timing_pkg::CNT_MAX) begin
        vCnt_ff <= 11'(vCnt_ff + 11'h001);
      end
      pixCnt_ff <= activeNow ? 11'(pixCnt_ff + 11'h001) : 11'h000;
      if (frameStart) begin
        lineCnt_ff <= 11'h000;
        frameCnt_ff <= 2'(frameCnt_ff + 2'h1);
      end else if (lineEnd) begin
        lineCnt_ff <= 11'(lineCnt_ff + 11'h001);
      end
    end
  end

  // 8-bit level to 6-bit code, rounding up by frame-rate threshold
  function automatic logic [5:0] toGray(input logic [7:0] v, input logic [1:0] phase,
                                        input logic dith);
    logic [6:0] sum;
    sum = {1'h0, v[7:2]} + {6'h00, (dith && (v[1:0] > phase))};
    toGray = sum[6] ? tft_timing_pkg::GRAY_MAX : sum[5:0];
  endfunction

  // colour bars replace host data in pattern mode
  tft_timing_pkg::pix_in_t pixSrc;
  assign pixSrc = patternOn ? '{red: {8{pixCnt_ff[6]}}, green: {8{pixCnt_ff[7]}},
    blue: {8{pixCnt_ff[8]}}} : syncd.pix;
  wire [1:0] spatial = 2'(pixCnt_ff[1:0] + lineCnt_ff[1:0]);
  wire [1:0] phase = cfg_ff.frame_rate_dither ? 2'(frameCnt_ff + spatial) : frameCnt_ff;
  wire dith = ~cfg_ff.dither_disable;
  // a normally white panel drives the complement code; invert stacks on top
  wire [5:0] flip = {tft_timing_pkg::GRAY_W{cfg_ff.data_invert ^ cfg_ff.white_default_select}};
  wire [5:0] redCode = toGray(pixSrc.red, phase, dith) ^ flip;
  wire [5:0] greenCode = toGray(pixSrc.green, phase, dith) ^ flip;
  wire [5:0] blueCode = toGray(pixSrc.blue, phase, dith) ^ flip;

  // split of an 800-wide line between the two chips
  wire leftChip = isPrimary ~^ cfg_ff.primary_side_select;
  wire wide = cascadeOn & (hWidth == tft_timing_pkg::H_ACT_800);
  wire firstHalf = pixCnt_ff < tft_timing_pkg::PIX_PER_CHIP;
  wire mine = ~wide | (firstHalf == leftChip);
  wire [10:0] localX = (wide & ~firstHalf) ? 11'(pixCnt_ff - tft_timing_pkg::PIX_PER_CHIP) :
    pixCnt_ff;
  wire [10:0] triple = 11'({localX[9:0], 1'h0} + localX);
  wire [10:0] column = cfg_ff.source_shift_direction ? triple :
    11'(tft_timing_pkg::LAST_TRIPLET - triple);
  wire dotPhase = cfg_ff.dual_gate_enable ? pixCnt_ff[1] : pixCnt_ff[0];
  wire forward = isPrimary & wide & ~mine & pixTick & activeNow;

  assign nxt_pixOut = '{valid: pixTick & activeNow & mine, column: column, red: redCode,
    green: greenCode, blue: blueCode, polarity: dotPhase ^ lineCnt_ff[0] ^ frameCnt_ff[0]};

  always_ff @(posedge clk_sys or negedge rstn_ff) begin
    if (!rstn_ff) begin
      column_outputs <= '0;
      fwdData_ff <= 18'h00000;
      chainClk_ff <= 1'h0;
    end else begin
      column_outputs <= nxt_pixOut;
      if (forward) begin
        fwdData_ff <= {redCode, greenCode, blueCode};
        chainClk_ff <= ~chainClk_ff;
      end
    end
  end

  // gate timing
  wire scan = cfg_ff.gate_scan_direction;
  assign nxt_gate = '{vstart_a: vstartOn_ff & scan, vstart_b: vstartOn_ff & ~scan,
    dir: scan, oe: hCnt_ff < tft_timing_pkg::OEV_TICKS,
    shift_clk: hCnt_ff < tft_timing_pkg::CKV_TICKS, load_n: ~loadPulse_ff};

  always_ff @(posedge clk_sys or negedge rstn_ff) begin
    if (!rstn_ff) begin
      vstartOn_ff <= 1'h0;
      loadPulse_ff <= 1'h0;
      gate_ff <= tft_timing_pkg::GATE_IDLE;
    end else begin
      if (frameStart) begin
        vstartOn_ff <= 1'h1;
      end else if (lineStart) begin
        vstartOn_ff <= 1'h0;
      end
      loadPulse_ff <= lineEnd;
      gate_ff <= nxt_gate;
    end
  end

  // bus placement: data toward the partner, gate signals elsewhere
  wire [17:0] gateBus = (18'(gate_ff.oe) << tft_timing_pkg::MIO_OE) |
    (18'(gate_ff.dir) << tft_timing_pkg::MIO_DIR) |
    (18'(gate_ff.shift_clk) << tft_timing_pkg::MIO_CLK) |
    (18'(gate_ff.vstart_a) << tft_timing_pkg::MIO_STA) |
    (18'(gate_ff.vstart_b) << tft_timing_pkg::MIO_STB) |
    (18'(gate_ff.vstart_a) << tft_timing_pkg::MIO_STA2) |
    (18'(gate_ff.load_n) << tft_timing_pkg::MIO_LOAD);
  wire drive = running & isPrimary;
  wire rData = cascadeOn & cfg_ff.primary_side_select;
  wire lData = cascadeOn & ~cfg_ff.primary_side_select;
  wire [17:0] nxt_rOut = rData ? fwdData_ff : gateBus;
  wire [17:0] nxt_lOut = lData ? fwdData_ff : gateBus;
  wire [17:0] nxt_rOe = ~drive ? 18'h00000 :
    (rData ? tft_timing_pkg::ALL_MASK : tft_timing_pkg::GATE_MASK);
  wire [17:0] nxt_lOe = ~drive ? 18'h00000 :
    (lData ? tft_timing_pkg::ALL_MASK : tft_timing_pkg::GATE_MASK);

  always_ff @(posedge clk_sys or negedge rstn_ff) begin
    if (!rstn_ff) begin
      right_multi_io_out <= 18'h00000;
      right_multi_io_oe <= 18'h00000;
      left_multi_io_out <= 18'h00000;
      left_multi_io_oe <= 18'h00000;
      chain_clock_out <= 1'h0;
      chain_clock_oe <= 1'h0;
    end else begin
      right_multi_io_out <= nxt_rOut;
      right_multi_io_oe <= nxt_rOe;
      left_multi_io_out <= nxt_lOut;
      left_multi_io_oe <= nxt_lOe;
      chain_clock_out <= chainClk_ff;
      chain_clock_oe <= drive & cascadeOn;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn_ff);

  property p_reset_quiet;
    @(posedge clk_sys) disable iff (1'b0)
    !rstn_ff |-> !column_outputs.valid && right_multi_io_oe == 18'h0 && !chain_clock_oe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("output active in reset");

  property p_dual_no_cascade;
    cfg_ff.dual_gate_enable |=> !chain_clock_oe;
  endproperty
  a_dual_no_cascade: assert property (p_dual_no_cascade) else $error("cascade in dual gate");

  property p_standby_hiz;
    !syncd.cfg.standby_n |=> left_multi_io_oe == 18'h0 && right_multi_io_oe == 18'h0 &&
      !chain_clock_oe && !column_outputs.valid;
  endproperty
  a_standby_hiz: assert property (p_standby_hiz) else $error("driving in standby");

  property p_secondary_quiet;
    !cfg_ff.primary_role_select |=> left_multi_io_oe == 18'h0 && right_multi_io_oe == 18'h0;
  endproperty
  a_secondary_quiet: assert property (p_secondary_quiet) else $error("secondary drives");

  property p_start_select;
    gate_ff.vstart_b |-> !$past(cfg_ff.gate_scan_direction) && !gate_ff.dir;
  endproperty
  a_start_select: assert property (p_start_select) else $error("wrong start output");

  property p_cfg_frame;
    cfgValid_ff && !frameStart |=> $stable(cfg_ff);
  endproperty
  a_cfg_frame: assert property (p_cfg_frame) else $error("config changed mid frame");

  property p_edge;
    column_outputs.valid && !$past(patternOn) |->
      $past(syncd.pclk) == $past(cfg_ff.sample_edge_select);
  endproperty
  a_edge: assert property (p_edge) else $error("sampled on wrong edge");

  property p_de_gate;
    column_outputs.valid && $past(deMode) |-> $past(syncd.de);
  endproperty
  a_de_gate: assert property (p_de_gate) else $error("pixel outside data valid");

  property p_first_column;
    pixTick && activeNow && localX == 11'h000 && !cfg_ff.source_shift_direction && mine
      |=> column_outputs.valid && column_outputs.column == tft_timing_pkg::LAST_TRIPLET;
  endproperty
  a_first_column: assert property (p_first_column) else $error("shift left order");

  property p_dither_off;
    column_outputs.valid && $past(cfg_ff.dither_disable) && !$past(patternOn) |->
      (column_outputs.red ^ $past(flip)) == $past(syncd.pix.red[7:2]);
  endproperty
  a_dither_off: assert property (p_dither_off) else $error("dither while disabled");
endmodule
`default_nettype wire

// >>> sim/host_video_model.sv
// behavioural host driving parallel video in data-valid timing
`timescale 1ns/1ns
`default_nettype none
module host_video_model (
  // clock
  input wire logic clk,
  // video pins
  output logic pclk,
  output logic lineSyncN,
  output logic frameSyncN,
  output logic dataValid,
  output tft_timing_pkg::pix_in_t pix
);
  initial begin
    pclk = 1'h0;
    lineSyncN = 1'h1;
    frameSyncN = 1'h1;
    dataValid = 1'h0;
    pix = '0;
  end
  // two cycles a half period keeps the clock at 12.5 MHz, legal for 400 columns
  task automatic half(input logic lvl);
    @(negedge clk);
    pclk = lvl;
    @(negedge clk);
  endtask
  task automatic send_line(input int n, input logic [7:0] v, input logic rise);
    frameSyncN = 1'h0;
    half(~rise);
    half(rise);
    frameSyncN = 1'h1;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      dataValid = 1'h1;
      pix = '{red: v, green: v, blue: v};
      pclk = ~rise;
      @(negedge clk);
      half(rise);
    end
    @(negedge clk);
    dataValid = 1'h0;
    // released data shows the inverse, never the last value
    pix = ~pix;
    pclk = ~rise;
    @(negedge clk);
    repeat (20) begin
      half(rise);
      half(~rise);
    end
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the pin-configured source timing front end
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  tft_timing_pkg::cfg_t cfg = tft_timing_pkg::CFG_DEFAULT;
  tft_timing_pkg::cfg_t base;
  tft_timing_pkg::cfg_t c;
  tft_timing_pkg::pix_in_t pix;
  tft_timing_pkg::pix_out_t colOut;
  logic pclk, lsN, fsN, dv, chainOut, chainOe, anyOe, dirSeen, anyChain;
  logic [17:0] rOut, rOe, lOut, lOe;
  logic [10:0] firstCol;
  logic [5:0] firstRed;
  logic [3:0] pols;
  int bad_count = 0;
  int n_compared = 0;
  int nValid = 0;
  always #10 clk_sys = ~clk_sys;
  host_video_model u_host_video_model (.clk(clk_sys), .pclk(pclk), .lineSyncN(lsN),
    .frameSyncN(fsN), .dataValid(dv), .pix(pix));
  tft_source_timing_pin_config u_tft_source_timing_pin_config (.clk_sys(clk_sys),
    .resetn(resetn), .red_in(pix.red), .green_in(pix.green), .blue_in(pix.blue),
    .pixel_clock_in(pclk), .line_sync_n(lsN), .frame_sync_n(fsN), .input_data_valid(dv),
    .resolution_select(cfg.res), .dither_disable(cfg.dither_disable),
    .frame_rate_dither(cfg.frame_rate_dither), .sample_edge_select(cfg.sample_edge_select),
    .dual_gate_enable(cfg.dual_gate_enable), .standby_n(cfg.standby_n),
    .primary_role_select(cfg.primary_role_select),
    .primary_side_select(cfg.primary_side_select),
    .source_shift_direction(cfg.source_shift_direction),
    .gate_scan_direction(cfg.gate_scan_direction),
    .self_pattern_enable(cfg.self_pattern_enable), .chain_enable(cfg.chain_enable),
    .white_default_select(cfg.white_default_select), .data_invert(cfg.data_invert),
    .data_valid_mode(cfg.de_mode), .column_outputs(colOut), .right_multi_io_in(18'h0),
    .right_multi_io_out(rOut), .right_multi_io_oe(rOe), .left_multi_io_in(18'h0),
    .left_multi_io_out(lOut), .left_multi_io_oe(lOe), .chain_clock_in(1'h0),
    .chain_clock_out(chainOut), .chain_clock_oe(chainOe));
  always @(posedge clk_sys) begin
    if (colOut.valid === 1'h1) begin
      if (nValid == 0) begin
        firstCol <= colOut.column;
        firstRed <= colOut.red;
      end
      nValid <= nValid + 1;
      pols <= {pols[2:0], colOut.polarity};
    end
    if (|rOe) anyOe <= 1'h1;
    if (rOe[tft_timing_pkg::MIO_DIR]) dirSeen <= rOut[tft_timing_pkg::MIO_DIR];
    if (chainOe) anyChain <= 1'h1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // pins settle before release because config is caught leaving reset
  task automatic start(input tft_timing_pkg::cfg_t k);
    @(negedge clk_sys);
    resetn = 1'h0;
    cfg = k;
    repeat (5) @(negedge clk_sys);
    check(colOut, 32'h0);
    check(rOe, 32'h0);
    resetn = 1'h1;
    repeat (8) @(negedge clk_sys);
    nValid = 0;
    anyOe = 1'h0;
    anyChain = 1'h0;
    dirSeen = 1'hx;
  endtask
  task automatic t_plain();
    start(base);
    u_host_video_model.send_line(4, 8'h84, 1'h0);
    check(nValid, 4);
    check(firstCol, 32'h0);
    check(firstRed, 32'h1e);
    check(anyOe, 32'h1);
    check(dirSeen, 32'h0);
    check(pols, 32'ha);
  endtask
  task automatic t_dither();
    c = base;
    c.dither_disable = 1'h0;
    start(c);
    u_host_video_model.send_line(2, 8'h87, 1'h0);
    check(firstRed, 32'h1d);
  endtask
  task automatic t_pattern();
    c = base;
    c.self_pattern_enable = 1'h1;
    start(c);
    repeat (22000) @(negedge clk_sys);
    check(nValid == 0, 32'h0);
    check(firstRed, 32'h3f);
    check(firstCol, 32'h0);
  endtask
  task automatic t_reverse();
    c = base;
    c.source_shift_direction = 1'h0;
    c.data_invert = 1'h1;
    c.gate_scan_direction = 1'h1;
    start(c);
    u_host_video_model.send_line(2, 8'h84, 1'h0);
    check(firstCol, 32'h4ad);
    check(firstRed, 32'h21);
    check(dirSeen, 32'h1);
  endtask
  task automatic t_rise();
    c = base;
    c.sample_edge_select = 1'h1;
    c.white_default_select = 1'h0;
    start(c);
    u_host_video_model.send_line(3, 8'h84, 1'h1);
    check(nValid, 3);
    check(firstRed, 32'h21);
  endtask
  task automatic t_idle_roles();
    c = base;
    c.standby_n = 1'h0;
    start(c);
    u_host_video_model.send_line(3, 8'h84, 1'h0);
    check(nValid, 0);
    check(anyOe, 32'h0);
    c = base;
    c.primary_role_select = 1'h0;
    start(c);
    u_host_video_model.send_line(3, 8'h84, 1'h0);
    check(anyOe, 32'h0);
    check(nValid, 3);
  endtask
  // 400 columns only: 800 columns need a pixel clock above what the host model makes
  task automatic t_dual();
    c = base;
    c.chain_enable = 1'h1;
    start(c);
    u_host_video_model.send_line(2, 8'h84, 1'h0);
    check(anyChain, 32'h1);
    check(lOe, tft_timing_pkg::ALL_MASK);
    check(rOe, tft_timing_pkg::GATE_MASK);
    c.primary_side_select = 1'h1;
    start(c);
    u_host_video_model.send_line(2, 8'h84, 1'h0);
    check(rOe, tft_timing_pkg::ALL_MASK);
    check(lOe, tft_timing_pkg::GATE_MASK);
    c = base;
    c.chain_enable = 1'h1;
    c.dual_gate_enable = 1'h1;
    start(c);
    u_host_video_model.send_line(4, 8'h84, 1'h0);
    check(nValid, 4);
    check(anyChain, 32'h0);
    check(pols, 32'hc);
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    base = tft_timing_pkg::CFG_DEFAULT;
    base.res = tft_timing_pkg::RES_400X480;
    base.chain_enable = 1'h0;
    t_plain();
    t_reverse();
    t_rise();
    t_idle_roles();
    t_dual();
    t_dither();
    t_pattern();
    report_and_stop();
  end
  // all scenarios need about 23000 cycles, the 22000-cycle pattern run most of them
  initial begin
    #1000000;
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
